// File: design/lcrs_cfg.svh
// constants for the latched control and range shadow block
// Notes on behaviour
// R1 - latched control holds pre-refresh settings; invalid before first
// R2 - sampling mode field bits 15-12, one mode
// R3 - codes 0-3: adaptive 1024/256/64/8 SPS, 0 default
// R4 - codes 4-7: fixed 1024/256/64/8 SPS
// R5 - code 8 single-shot, 9 single-shot 8x
// R6 - code a fast mode, b burst mode
// R7 - code f sleep; c-e reserved
// R8 - pin2 function bits 11-10, default input
// R9 - pin1 function bits 9-8, default slow input
// R10 - slow pin high forces 8 SPS
// R11 - gpio pin data lives in gpio data register
// R12 - channel-off mask bits 7-4 excludes channels
// R13 - pointer skips disabled channels unless overridden
// R14 - channel-off reset value depends on variant
// R15 - latched control bits 3-0 read zero
// R16 - latched range holds pre-refresh range settings
// R17 - latched registers valid 1 ms after refresh
// R18 - sense range: unipolar, bipolar 100, 50, reserved
// R19 - channel 4 sense range at bits 9-8
// R20 - bus range: unipolar 32, bipolar 32, 16, reserved
// R21 - refresh copies active settings before new activate
`ifndef LCRS_CFG_SVH
`define LCRS_CFG_SVH

`define LCRS_OFS_LATCHED_CONTROL 8'h23
`define LCRS_OFS_LATCHED_RANGE 8'h24
`define LCRS_CTRL_RESET 16'h0700
`define LCRS_RANGE_RESET 16'h0000
`define LCRS_ZERO16 16'h0000

`define LCRS_MODE_HI 15
`define LCRS_MODE_LO 12
`define LCRS_PIN2_HI 11
`define LCRS_PIN2_LO 10
`define LCRS_PIN1_HI 9
`define LCRS_PIN1_LO 8
`define LCRS_CHOFF_HI 7
`define LCRS_CHOFF_LO 4
`define LCRS_UNIMP_HI 3
`define LCRS_UNIMP_LO 0
`define LCRS_UNIMP_VAL 4'h0

`define LCRS_MODE_ADAPT_1024 4'h0
`define LCRS_MODE_ADAPT_8 4'h3
`define LCRS_MODE_FIXED_1024 4'h4
`define LCRS_MODE_FIXED_8 4'h7
`define LCRS_MODE_SINGLE 4'h8
`define LCRS_MODE_SINGLE_8X 4'h9
`define LCRS_MODE_FAST 4'ha
`define LCRS_MODE_BURST 4'hb
`define LCRS_MODE_SLEEP 4'hf
`define LCRS_RATE_8SPS 2'h3

`define LCRS_PIN_ALERT 2'h0
`define LCRS_PIN_GPIO_IN 2'h1
`define LCRS_PIN_GPIO_OUT 2'h2
`define LCRS_PIN_SLOW 2'h3

`define LCRS_RANGE_FIELDS 8
`define LCRS_RANGE_W 2
`define LCRS_RANGE_TOP 15
`define LCRS_RANGE_UNI 2'h0
`define LCRS_RANGE_BI_FULL 2'h1
`define LCRS_RANGE_BI_HALF 2'h2

`define LCRS_VARIANT_4CH 2'h0
`define LCRS_VARIANT_3CH 2'h1
`define LCRS_VARIANT_2CH 2'h2
`define LCRS_CHOFF_4CH 4'h0
`define LCRS_CHOFF_3CH 4'h1
`define LCRS_CHOFF_2CH 4'h3
`define LCRS_CHOFF_1CH 4'h7

`define LCRS_SETTLE_TIME_US 1000
`define LCRS_CLK_MHZ 250
`define LCRS_SETTLE_CNT_W 18
`define LCRS_SETTLE_ZERO 18'h00000

`endif

// File: design/lcrs_pkg.sv
// types of the latched control and range shadow block
`include "lcrs_cfg.svh"
package lcrs_pkg;

  typedef enum logic [1:0] {
    LCRS_ST_UNSET = 2'h0,
    LCRS_ST_SETTLE = 2'h1,
    LCRS_ST_VALID = 2'h3
  } lcrs_valid_st_t;

  typedef struct packed {
    lcrs_valid_st_t vst;
    logic [`LCRS_SETTLE_CNT_W-1:0] settle_cnt;
    logic strap_done;
    logic latched_valid;
    logic first_refresh_seen;
    logic [15:0] latched_control;
    logic [15:0] latched_range;
    logic [15:0] rdata;
    logic rvalid;
    logic mode_adaptive;
    logic mode_fixed;
    logic mode_single;
    logic mode_single_8x;
    logic mode_fast;
    logic mode_burst;
    logic mode_sleep;
    logic mode_reserved;
    logic [1:0] rate_sel;
    logic slow_override;
    logic [1:0] pin1_function_select;
    logic [1:0] pin2_function_select;
    logic [1:0] alert_sel;
    logic [1:0] gpio_in_sel;
    logic [1:0] gpio_out_sel;
    logic [3:0] channel_active;
    logic [3:0] pointer_skip;
    logic [7:0] range_unipolar;
    logic [7:0] range_bipolar_full;
    logic [7:0] range_bipolar_half;
    logic [7:0] range_reserved;
  } lcrs_state_t;

endpackage

// File: design/lcrs_range_if.sv
// carrier between the shadow top and a range field decoder
`timescale 1ns/100ps
`default_nettype none
interface lcrs_range_if;
  logic [1:0] code;
  logic unipolar;
  logic bipolar_full;
  logic bipolar_half;
  logic reserved;
  modport dec (input code, output unipolar, output bipolar_full, output bipolar_half,
    output reserved);
  modport user (output code, input unipolar, input bipolar_full, input bipolar_half,
    input reserved);
endinterface
`default_nettype wire

// File: design/lcrs_range_decode.sv
// decoder for one two-bit full-scale range field
`timescale 1ns/100ps
`default_nettype none
`include "lcrs_cfg.svh"
module lcrs_range_decode (
  lcrs_range_if.dec rng
);
  // same encoding serves sense and bus fields, only the scale differs
  // R18 sense range encoding
  // R20 bus range encoding
  always_comb
  begin
    rng.unipolar = 1'b0;
    rng.bipolar_full = 1'b0;
    rng.bipolar_half = 1'b0;
    rng.reserved = 1'b0;
    unique case (rng.code)
      `LCRS_RANGE_UNI: rng.unipolar = 1'b1;
      `LCRS_RANGE_BI_FULL: rng.bipolar_full = 1'b1;
      `LCRS_RANGE_BI_HALF: rng.bipolar_half = 1'b1;
      default: rng.reserved = 1'b1;
    endcase
  end
endmodule // lcrs_range_decode
`default_nettype wire

// File: design/lcrs_top.sv
// latched control and range shadow registers with setting decode
`timescale 1ns/100ps
`default_nettype none
`include "lcrs_cfg.svh"
module lcrs_top #(
  parameter int SETTLE_CYCLES = `LCRS_SETTLE_TIME_US * `LCRS_CLK_MHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic refresh,
  input wire logic [15:0] active_control,
  input wire logic [15:0] active_range,
  input wire logic [1:0] variant,
  input wire logic pin1_level,
  input wire logic pin2_level,
  input wire logic pointer_skip_override,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic [15:0] latched_control,
  output logic [15:0] latched_range_config,
  output logic latched_valid,
  output logic first_refresh_seen,
  output logic mode_adaptive,
  output logic mode_fixed,
  output logic mode_single,
  output logic mode_single_8x,
  output logic mode_fast,
  output logic mode_burst,
  output logic mode_sleep,
  output logic mode_reserved,
  output logic [1:0] rate_sel,
  output logic slow_override,
  output logic [1:0] pin1_function_select,
  output logic [1:0] pin2_function_select,
  output logic [1:0] alert_sel,
  output logic [1:0] gpio_in_sel,
  output logic [1:0] gpio_out_sel,
  output logic [3:0] channel_active,
  output logic [3:0] pointer_skip,
  output logic [3:0] sense_unipolar,
  output logic [3:0] sense_bipolar_full,
  output logic [3:0] sense_bipolar_half,
  output logic [3:0] sense_reserved,
  output logic [3:0] bus_unipolar,
  output logic [3:0] bus_bipolar_full,
  output logic [3:0] bus_bipolar_half,
  output logic [3:0] bus_reserved
);

  lcrs_pkg::lcrs_state_t s;
  lcrs_pkg::lcrs_state_t next_s;

  logic [7:0] dec_unipolar;
  logic [7:0] dec_bipolar_full;
  logic [7:0] dec_bipolar_half;
  logic [7:0] dec_reserved;

  lcrs_range_if rng_if [`LCRS_RANGE_FIELDS] ();

  // field i sits at bits 15-2i..14-2i: sense ch1..4 first, then bus ch1..4
  genvar gi;
  generate
    for (gi = 0; gi < `LCRS_RANGE_FIELDS; gi++)
    begin : g_rng
      // R19 channel 4 sense field
      assign rng_if[gi].code = s.latched_range[`LCRS_RANGE_TOP - 2*gi -: `LCRS_RANGE_W];
      lcrs_range_decode u_dec (
        .rng(rng_if[gi])
      );
      assign dec_unipolar[gi] = rng_if[gi].unipolar;
      assign dec_bipolar_full[gi] = rng_if[gi].bipolar_full;
      assign dec_bipolar_half[gi] = rng_if[gi].bipolar_half;
      assign dec_reserved[gi] = rng_if[gi].reserved;
    end
  endgenerate

  logic [3:0] mode_code;
  logic [3:0] choff_now;
  logic [1:0] pin1_now;
  logic [1:0] pin2_now;
  logic [3:0] strap_choff;
  logic slow_now;

  assign mode_code = active_control[`LCRS_MODE_HI:`LCRS_MODE_LO];
  assign choff_now = active_control[`LCRS_CHOFF_HI:`LCRS_CHOFF_LO];
  assign pin1_now = active_control[`LCRS_PIN1_HI:`LCRS_PIN1_LO];
  assign pin2_now = active_control[`LCRS_PIN2_HI:`LCRS_PIN2_LO];

  // R10 slow pin override
  assign slow_now = (pin1_now == `LCRS_PIN_SLOW && pin1_level)
    || (pin2_now == `LCRS_PIN_SLOW && pin2_level);

  // R14 variant reset mask
  always_comb
  begin
    unique case (variant)
      `LCRS_VARIANT_4CH: strap_choff = `LCRS_CHOFF_4CH;
      `LCRS_VARIANT_3CH: strap_choff = `LCRS_CHOFF_3CH;
      `LCRS_VARIANT_2CH: strap_choff = `LCRS_CHOFF_2CH;
      default: strap_choff = `LCRS_CHOFF_1CH;
    endcase
  end

  always_comb
  begin
    next_s = s;
    next_s.rvalid = 1'b0;

    // strap is caught once after reset release, never under the reset itself
    if (!s.strap_done)
    begin
      next_s.strap_done = 1'b1;
      // R14 variant channel-off default
      next_s.latched_control[`LCRS_CHOFF_HI:`LCRS_CHOFF_LO] = strap_choff;
    end

    // range shadow is software writable; a refresh in the same cycle wins
    if (reg_wr && reg_addr == `LCRS_OFS_LATCHED_RANGE)
    begin
      next_s.latched_range = reg_wdata;
    end

    // R21 capture before activate
    if (refresh)
    begin
      // R1 latch control in force
      next_s.latched_control = active_control;
      // R15 low nibble zero
      next_s.latched_control[`LCRS_UNIMP_HI:`LCRS_UNIMP_LO] = `LCRS_UNIMP_VAL;
      // R16 latch range in force
      next_s.latched_range = active_range;
      next_s.first_refresh_seen = 1'b1;
    end

    // R17 settle timer
    unique case (s.vst)
      lcrs_pkg::LCRS_ST_UNSET:
      begin
        if (refresh)
        begin
          next_s.vst = lcrs_pkg::LCRS_ST_SETTLE;
          next_s.settle_cnt = `LCRS_SETTLE_CNT_W'(SETTLE_CYCLES - 1);
        end
      end
      lcrs_pkg::LCRS_ST_SETTLE:
      begin
        if (refresh)
        begin
          next_s.settle_cnt = `LCRS_SETTLE_CNT_W'(SETTLE_CYCLES - 1);
        end
        else if (s.settle_cnt == `LCRS_SETTLE_ZERO)
        begin
          next_s.vst = lcrs_pkg::LCRS_ST_VALID;
        end
        else
        begin
          next_s.settle_cnt = s.settle_cnt - `LCRS_SETTLE_CNT_W'(1);
        end
      end
      lcrs_pkg::LCRS_ST_VALID:
      begin
        // a new refresh makes the shadow stale until its dataset settles
        if (refresh)
        begin
          next_s.vst = lcrs_pkg::LCRS_ST_SETTLE;
          next_s.settle_cnt = `LCRS_SETTLE_CNT_W'(SETTLE_CYCLES - 1);
        end
      end
      default:
      begin
        next_s.vst = lcrs_pkg::LCRS_ST_UNSET;
        next_s.settle_cnt = `LCRS_SETTLE_ZERO;
      end
    endcase
    // R1 invalid before first refresh
    next_s.latched_valid = (next_s.vst == lcrs_pkg::LCRS_ST_VALID);

    // register reads answer one cycle later; unmapped addresses read zero
    if (reg_rd)
    begin
      next_s.rvalid = 1'b1;
      unique case (reg_addr)
        `LCRS_OFS_LATCHED_CONTROL:
        begin
          // R15 unimplemented bits zero
          next_s.rdata = {s.latched_control[15:`LCRS_CHOFF_LO], `LCRS_UNIMP_VAL};
        end
        `LCRS_OFS_LATCHED_RANGE: next_s.rdata = s.latched_range;
        default: next_s.rdata = `LCRS_ZERO16;
      endcase
    end

    // R2 one mode at a time
    // reserved codes keep the last legal mode so exactly one stays in effect
    if (mode_code >= `LCRS_MODE_ADAPT_1024 && mode_code <= `LCRS_MODE_ADAPT_8)
    begin
      // R3 adaptive accumulation modes
      next_s.mode_adaptive = 1'b1;
      next_s.mode_fixed = 1'b0;
      next_s.mode_single = 1'b0;
      next_s.mode_single_8x = 1'b0;
      next_s.mode_fast = 1'b0;
      next_s.mode_burst = 1'b0;
      next_s.mode_sleep = 1'b0;
      next_s.mode_reserved = 1'b0;
      next_s.rate_sel = mode_code[1:0];
    end
    else if (mode_code >= `LCRS_MODE_FIXED_1024 && mode_code <= `LCRS_MODE_FIXED_8)
    begin
      // R4 fixed rate modes
      next_s.mode_adaptive = 1'b0;
      next_s.mode_fixed = 1'b1;
      next_s.mode_single = 1'b0;
      next_s.mode_single_8x = 1'b0;
      next_s.mode_fast = 1'b0;
      next_s.mode_burst = 1'b0;
      next_s.mode_sleep = 1'b0;
      next_s.mode_reserved = 1'b0;
      next_s.rate_sel = mode_code[1:0];
    end
    else if (mode_code == `LCRS_MODE_SINGLE || mode_code == `LCRS_MODE_SINGLE_8X)
    begin
      // R5 single-shot and 8x average
      next_s.mode_adaptive = 1'b0;
      next_s.mode_fixed = 1'b0;
      next_s.mode_single = (mode_code == `LCRS_MODE_SINGLE);
      next_s.mode_single_8x = (mode_code == `LCRS_MODE_SINGLE_8X);
      next_s.mode_fast = 1'b0;
      next_s.mode_burst = 1'b0;
      next_s.mode_sleep = 1'b0;
      next_s.mode_reserved = 1'b0;
    end
    else if (mode_code == `LCRS_MODE_FAST || mode_code == `LCRS_MODE_BURST)
    begin
      // R6 fast and burst modes
      next_s.mode_adaptive = 1'b0;
      next_s.mode_fixed = 1'b0;
      next_s.mode_single = 1'b0;
      next_s.mode_single_8x = 1'b0;
      next_s.mode_fast = (mode_code == `LCRS_MODE_FAST);
      next_s.mode_burst = (mode_code == `LCRS_MODE_BURST);
      next_s.mode_sleep = 1'b0;
      next_s.mode_reserved = 1'b0;
    end
    else if (mode_code == `LCRS_MODE_SLEEP)
    begin
      // R7 sleep stops sampling
      next_s.mode_adaptive = 1'b0;
      next_s.mode_fixed = 1'b0;
      next_s.mode_single = 1'b0;
      next_s.mode_single_8x = 1'b0;
      next_s.mode_fast = 1'b0;
      next_s.mode_burst = 1'b0;
      next_s.mode_sleep = 1'b1;
      next_s.mode_reserved = 1'b0;
    end
    else
    begin
      // R7 reserved codes flagged
      next_s.mode_reserved = 1'b1;
    end

    // R10 force 8 SPS
    next_s.slow_override = slow_now;
    if (slow_now)
    begin
      next_s.rate_sel = `LCRS_RATE_8SPS;
    end

    // R8 pin2 function decode
    next_s.pin2_function_select = pin2_now;
    // R9 pin1 function decode
    next_s.pin1_function_select = pin1_now;
    next_s.alert_sel = {pin2_now == `LCRS_PIN_ALERT, pin1_now == `LCRS_PIN_ALERT};
    // R11 gpio data register owners
    next_s.gpio_in_sel = {pin2_now == `LCRS_PIN_GPIO_IN, pin1_now == `LCRS_PIN_GPIO_IN};
    next_s.gpio_out_sel = {pin2_now == `LCRS_PIN_GPIO_OUT, pin1_now == `LCRS_PIN_GPIO_OUT};

    // R12 disabled channels excluded
    // bit 7 of the mask is channel 1, so the vector is reversed to index by channel
    next_s.channel_active = ~{choff_now[0], choff_now[1], choff_now[2], choff_now[3]};
    // R13 pointer skip unless overridden
    next_s.pointer_skip = pointer_skip_override ? 4'h0
      : {choff_now[0], choff_now[1], choff_now[2], choff_now[3]};

    // decoded ranges trail the shadow by one cycle
    next_s.range_unipolar = dec_unipolar;
    next_s.range_bipolar_full = dec_bipolar_full;
    next_s.range_bipolar_half = dec_bipolar_half;
    next_s.range_reserved = dec_reserved;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.vst <= lcrs_pkg::LCRS_ST_UNSET;
      s.latched_control <= `LCRS_CTRL_RESET;
      s.latched_range <= `LCRS_RANGE_RESET;
      // R3 adaptive 1024 default
      s.mode_adaptive <= 1'b1;
      s.pin2_function_select <= `LCRS_PIN_GPIO_IN;
      s.pin1_function_select <= `LCRS_PIN_SLOW;
      s.gpio_in_sel <= 2'h2;
      s.channel_active <= 4'hf;
      s.range_unipolar <= 8'hff;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign latched_control = s.latched_control;
  assign latched_range_config = s.latched_range;
  assign latched_valid = s.latched_valid;
  assign first_refresh_seen = s.first_refresh_seen;
  assign mode_adaptive = s.mode_adaptive;
  assign mode_fixed = s.mode_fixed;
  assign mode_single = s.mode_single;
  assign mode_single_8x = s.mode_single_8x;
  assign mode_fast = s.mode_fast;
  assign mode_burst = s.mode_burst;
  assign mode_sleep = s.mode_sleep;
  assign mode_reserved = s.mode_reserved;
  assign rate_sel = s.rate_sel;
  assign slow_override = s.slow_override;
  assign pin1_function_select = s.pin1_function_select;
  assign pin2_function_select = s.pin2_function_select;
  assign alert_sel = s.alert_sel;
  assign gpio_in_sel = s.gpio_in_sel;
  assign gpio_out_sel = s.gpio_out_sel;
  assign channel_active = s.channel_active;
  assign pointer_skip = s.pointer_skip;
  assign sense_unipolar = s.range_unipolar[3:0];
  assign sense_bipolar_full = s.range_bipolar_full[3:0];
  assign sense_bipolar_half = s.range_bipolar_half[3:0];
  assign sense_reserved = s.range_reserved[3:0];
  assign bus_unipolar = s.range_unipolar[7:4];
  assign bus_bipolar_full = s.range_bipolar_full[7:4];
  assign bus_bipolar_half = s.range_bipolar_half[7:4];
  assign bus_reserved = s.range_reserved[7:4];

endmodule // lcrs_top
`default_nettype wire

// File: testbench/lcrs_top_sva.sv
// assertion checker watching the shadow block's top ports
`timescale 1ns/100ps
`default_nettype none
module lcrs_top_sva #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic refresh,
  input wire logic [15:0] active_control,
  input wire logic [15:0] active_range,
  input wire logic pin1_level,
  input wire logic pin2_level,
  input wire logic pointer_skip_override,
  input wire logic [15:0] latched_control,
  input wire logic [15:0] latched_range_config,
  input wire logic latched_valid,
  input wire logic mode_adaptive,
  input wire logic mode_fixed,
  input wire logic mode_single,
  input wire logic mode_single_8x,
  input wire logic mode_fast,
  input wire logic mode_burst,
  input wire logic mode_sleep,
  input wire logic [1:0] rate_sel,
  input wire logic slow_override,
  input wire logic [3:0] channel_active,
  input wire logic [3:0] pointer_skip,
  input wire logic [3:0] sense_bipolar_half,
  input wire logic [3:0] bus_reserved
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_clr;
    latched_control[3:0] == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("latched control low bits set");
  property p_lat;
    refresh |=> latched_control == {$past(active_control[15:4]), 4'h0}
      && latched_range_config == $past(active_range);
  endproperty
  a_lat: assert property (p_lat) else $error("shadow copy wrong");
  // the repeat counts assume the bench's settle value of 8
  property p_wait;
    refresh |=> (!latched_valid) [*8];
  endproperty
  a_wait: assert property (p_wait) else $error("shadow valid too early");
  property p_valid;
    refresh ##1 (!refresh) [*8] |=> latched_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("shadow valid late");
  property p_hot;
    $onehot({mode_adaptive, mode_fixed, mode_single, mode_single_8x, mode_fast, mode_burst,
      mode_sleep});
  endproperty
  a_hot: assert property (p_hot) else $error("mode flags not one-hot");
  property p_adfx;
    !active_control[15] |=> mode_fixed == $past(active_control[14])
      && (slow_override || rate_sel == $past(active_control[13:12]));
  endproperty
  a_adfx: assert property (p_adfx) else $error("rate mode decode wrong");
  property p_other;
    active_control[15:14] == 2'h2 |=> {mode_burst, mode_fast, mode_single_8x, mode_single}
      == 4'h1 << $past(active_control[13:12]);
  endproperty
  a_other: assert property (p_other) else $error("shot mode decode wrong");
  property p_slow;
    (active_control[9:8] == 2'h3 && pin1_level) || (active_control[11:10] == 2'h3 && pin2_level)
      |=> slow_override && rate_sel == 2'h3;
  endproperty
  a_slow: assert property (p_slow) else $error("slow pin ignored");
  property p_chan;
    1'b1 |=> channel_active == ~{$past(active_control[4]), $past(active_control[5]),
      $past(active_control[6]), $past(active_control[7])}
      && pointer_skip == ($past(pointer_skip_override) ? 4'h0 : ~channel_active);
  endproperty
  a_chan: assert property (p_chan) else $error("channel mask decode wrong");
  property p_rdec;
    1'b1 |=> sense_bipolar_half[0] == ($past(latched_range_config[15:14]) == 2'h2)
      && sense_bipolar_half[3] == ($past(latched_range_config[9:8]) == 2'h2)
      && bus_reserved[3] == ($past(latched_range_config[1:0]) == 2'h3);
  endproperty
  a_rdec: assert property (p_rdec) else $error("range decode wrong");
endmodule // lcrs_top_sva
`default_nettype wire

// File: testbench/lcrs_host.sv
// host model driving the shadow block's register port
`timescale 1ns/100ps
`default_nettype none
module lcrs_host (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // released address and data are inverted so a stale value never passes for a live one
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge clk);
    q = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule // lcrs_host
`default_nettype wire

// File: testbench/tb_lcrs_top.sv
// self-checking bench for the latched control and range shadow block
`timescale 1ns/100ps
`default_nettype none
module tb_lcrs_top;
  localparam int SETTLE = 8;
  logic clk, nrst, refresh, pin1_level, pin2_level, pointer_skip_override;
  logic [15:0] active_control, active_range, reg_wdata, reg_rdata, latched_control;
  logic [15:0] latched_range_config, lc_exp;
  logic [7:0] reg_addr;
  logic [1:0] variant, rate_sel, pin1_function_select, pin2_function_select;
  logic [1:0] alert_sel, gpio_in_sel, gpio_out_sel;
  logic reg_wr, reg_rd, reg_rvalid, latched_valid, first_refresh_seen, slow_override;
  logic mode_adaptive, mode_fixed, mode_single, mode_single_8x, mode_fast, mode_burst;
  logic mode_sleep, mode_reserved;
  logic [3:0] channel_active, pointer_skip, sense_unipolar, sense_bipolar_full;
  logic [3:0] sense_bipolar_half, sense_reserved, bus_unipolar, bus_bipolar_full;
  logic [3:0] bus_bipolar_half, bus_reserved;
  int num_errors, checks_done;

  lcrs_top #(.SETTLE_CYCLES(SETTLE)) u_lcrs_top (
    .clk, .nrst, .refresh, .active_control, .active_range, .variant, .pin1_level,
    .pin2_level, .pointer_skip_override, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .latched_control, .latched_range_config, .latched_valid,
    .first_refresh_seen, .mode_adaptive, .mode_fixed, .mode_single, .mode_single_8x,
    .mode_fast, .mode_burst, .mode_sleep, .mode_reserved, .rate_sel, .slow_override,
    .pin1_function_select, .pin2_function_select, .alert_sel, .gpio_in_sel, .gpio_out_sel,
    .channel_active, .pointer_skip, .sense_unipolar, .sense_bipolar_full,
    .sense_bipolar_half, .sense_reserved, .bus_unipolar, .bus_bipolar_full,
    .bus_bipolar_half, .bus_reserved
  );
  lcrs_host u_lcrs_host (
    .clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_rd, .reg_wdata
  );

  always #2 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    u_lcrs_host.access(1'b0, a, 16'h0000, q);
    chk("read data", exp, q);
  endtask
  task automatic do_reset(input logic [1:0] v);
    nrst = 1'b0;
    variant = v;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
  endtask
  task automatic t_reset;
    for (int v = 0; v < 4; v++)
    begin
      do_reset(2'(v));
      rd(8'h23, 16'h0700 | (16'((5'h1 << v) - 5'h1) << 4));
      rd(8'h24, 16'h0000);
      rd(8'h5e, 16'h0000);
      chk("valid before refresh", 16'h0000, 16'(latched_valid));
    end
    do_reset(2'h0);
    $display("test reset done");
  endtask
  task automatic t_refresh;
    int n;
    active_control = 16'h5a3c;
    active_range = 16'h1b6c;
    lc_exp = 16'h5a30;
    @(negedge clk);
    refresh = 1'b1;
    @(negedge clk);
    refresh = 1'b0;
    active_control = 16'h0000;
    chk("refresh seen", 16'h0001, 16'(first_refresh_seen));
    n = 1;
    while (latched_valid !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk("valid delay", 16'(SETTLE + 1), 16'(n));
    rd(8'h23, lc_exp);
    rd(8'h24, 16'h1b6c);
    $display("test refresh done");
  endtask
  task automatic t_modes;
    logic [6:0] exp_m, got_m;
    logic [3:0] c;
    exp_m = 7'h40;
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      active_control = {c, 12'h500};
      @(negedge clk);
      if (c < 4'h4) exp_m = 7'h40;
      else if (c < 4'h8) exp_m = 7'h20;
      else if (c < 4'hc) exp_m = 7'h10 >> c[1:0];
      else if (c == 4'hf) exp_m = 7'h01;
      got_m = {mode_adaptive, mode_fixed, mode_single, mode_single_8x, mode_fast,
        mode_burst, mode_sleep};
      chk("mode flags", 16'(exp_m), 16'(got_m));
      chk("reserved flag", 16'(c inside {[4'hc:4'he]}), 16'(mode_reserved));
      if (c < 4'h8) chk("rate", 16'(c[1:0]), 16'(rate_sel));
    end
    $display("test modes done");
  endtask
  task automatic t_pins;
    logic [1:0] f;
    logic [9:0] e;
    for (int i = 0; i < 8; i++)
    begin
      f = 2'(i);
      pin1_level = i[2];
      pin2_level = i[2];
      active_control = {4'h0, f, f, 8'h00};
      @(negedge clk);
      e = {{2{f == 2'h0}}, {2{f == 2'h1}}, {2{f == 2'h2}}, f, f};
      chk("pin decode", 16'(e), 16'({alert_sel, gpio_in_sel, gpio_out_sel,
        pin2_function_select, pin1_function_select}));
      chk("slow rate", 16'({3{f == 2'h3 && i[2]}}), 16'({slow_override, rate_sel}));
    end
    $display("test pins done");
  endtask
  task automatic t_chan;
    logic [3:0] m, act;
    for (int i = 0; i < 32; i++)
    begin
      m = 4'(i);
      pointer_skip_override = i[4];
      active_control = {8'h07, m, 4'h0};
      @(negedge clk);
      act = ~{m[0], m[1], m[2], m[3]};
      chk("active channels", 16'(act), 16'(channel_active));
      chk("pointer skip", 16'(i[4] ? 4'h0 : {m[0], m[1], m[2], m[3]}), 16'(pointer_skip));
    end
    $display("test channels done");
  endtask
  task automatic t_range;
    logic [15:0] v, e, q;
    for (int i = 0; i < 4; i++)
    begin
      v = {8{2'(i)}};
      e = 16'hf000 >> (4 * i);
      u_lcrs_host.access(1'b1, 8'h24, v, q);
      rd(8'h24, v);
      chk("sense decode", e, {sense_unipolar, sense_bipolar_full, sense_bipolar_half,
        sense_reserved});
      chk("bus decode", e, {bus_unipolar, bus_bipolar_full, bus_bipolar_half,
        bus_reserved});
    end
    u_lcrs_host.access(1'b1, 8'h23, 16'hffff, q);
    rd(8'h23, lc_exp);
    $display("test range done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    refresh = 1'b0;
    active_control = 16'h0000;
    active_range = 16'h0000;
    variant = 2'h0;
    pin1_level = 1'b0;
    pin2_level = 1'b0;
    pointer_skip_override = 1'b0;
    num_errors = 0;
    checks_done = 0;
    t_reset();
    t_refresh();
    t_modes();
    t_pins();
    t_chan();
    t_range();
    wrap_up();
  end
  // the whole run takes under two hundred cycles, so this leaves ample margin
  initial
  begin
    repeat (2000) @(negedge clk);
    num_errors++;
    wrap_up();
  end
endmodule // tb_lcrs_top

bind lcrs_top lcrs_top_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_lcrs_top_sva (
  .clk, .nrst, .refresh, .active_control, .active_range, .pin1_level, .pin2_level,
  .pointer_skip_override, .latched_control, .latched_range_config, .latched_valid,
  .mode_adaptive, .mode_fixed, .mode_single, .mode_single_8x, .mode_fast, .mode_burst,
  .mode_sleep, .rate_sel, .slow_override, .channel_active, .pointer_skip,
  .sense_bipolar_half, .bus_reserved
);
`default_nettype wire
